// ==== logic/sdmc_cfg.svh ====
`ifndef SDMC_CFG_SVH
`define SDMC_CFG_SVH
`define SDMC_IDX_ATT_L 7'h10
`define SDMC_IDX_ATT_R 7'h11
`define SDMC_IDX_MUTE 7'h12
`define SDMC_IDX_DEEMPH 7'h13
`define SDMC_IDX_FORMAT 7'h14
`define SDMC_IDX_PHASE 7'h16
`define SDMC_ATT_RESET 8'hff
`define SDMC_ATT_MUTE_MAX 8'h80
`define SDMC_FMT_RESET 3'h5
`define SDMC_DMF_RESERVED 2'h3
`define SDMC_FMT_RSV_MIN 3'h6
`define SDMC_STEP_FS 4'h8
`define SDMC_WORD_BITS 5'h10
`define SDMC_B_MUTE_L 0
`define SDMC_B_MUTE_R 1
`define SDMC_B_OVER 6
`define SDMC_B_SOFT_RESET_BIT 7
`define SDMC_B_DIS_L 0
`define SDMC_B_DIS_R 1
`define SDMC_B_DEEN 4
`define SDMC_B_DMF_LO 5
`define SDMC_B_DMF_HI 6
`define SDMC_B_FMT_LO 0
`define SDMC_B_FMT_HI 2
`define SDMC_B_FLT 5
`define SDMC_B_OUTPUT_PHASE_INVERT 0
`define SDMC_B_ZERO_FLAG_POLARITY 1
`define SDMC_B_ZERO_FLAG_GROUPING 2
`endif

// ==== logic/sdmc_pkg.sv ====
package sdmc_pkg;
    typedef logic [7:0] sdmc_code_t;
    typedef enum logic [1:0] {SDMC_IDLE, SDMC_STEP} sdmc_ramp_t;
endpackage

// ==== logic/sdmc_ramp.sv ====
`timescale 1ns/1ps
`include "sdmc_cfg.svh"
module sdmc_ramp
    import sdmc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic step,
    input wire sdmc_code_t target,
    input wire logic mute,
    output sdmc_code_t level
);
    sdmc_code_t level_q;
    sdmc_code_t goal;
    sdmc_code_t level_d;
    // Codes at or below the mute threshold all mean infinite attenuation
    assign goal = (mute || target <= `SDMC_ATT_MUTE_MAX) ? `SDMC_ATT_MUTE_MAX : target;
    assign level_d = !step ? level_q : (level_q < goal) ? level_q + 8'h01 :
                     (level_q > goal) ? level_q - 8'h01 : level_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || clr) begin
            level_q <= `SDMC_ATT_RESET;
        end else begin
            level_q <= level_d;
        end
    end
    assign level = level_q;
    property p_one_step;
        @(posedge sys_clk) disable iff (!rst_n || clr)
        step |=> (level_q == $past(level_q) + 8'h01) || (level_q == $past(level_q) - 8'h01)
                 || (level_q == $past(goal));
    endproperty
    a_one_step: assert property (p_one_step) else $error("Ramp moved more than one step");
    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n || clr)
        !step |=> $stable(level_q);
    endproperty
    a_hold: assert property (p_hold) else $error("Level moved without a step");
endmodule

// ==== logic/sdmc_top.sv ====
`timescale 1ns/1ps
`include "sdmc_cfg.svh"
// Overview of operation
// - Codes 129 to 255 attenuate by half a dB per code below 255.
// - Codes 0 to 128 give infinite attenuation, muting the channel.
// - Applied level walks one half dB step every 8 sample periods.
// - Both attenuation codes reset to all ones, no attenuation.
// - Left and right channels each have their own attenuation code.
// - Setting a soft mute bit ramps that channel down to mute.
// - Clearing soft mute ramps back up to the programmed level.
// - Soft mute bits: left at bit 0, right at bit 1, reset 0.
// - Oversampling bit picks modulator rate, resets to 0.
// - Writing soft reset bit as 1 restores every mode register default.
// - Output disable bit holds that output at bipolar zero.
// - De-emphasis enable bit switches the filter on, resets off.
// - Two-bit rate field: 44.1, 48, 32 kHz, 11 reserved.
// - Three-bit format field, default left-justified, 110/111 reserved.
// - Rolloff bit: 0 sharp by default, 1 slow.
// - Phase bit 1 inverts analog output polarity.
// - Zero flag polarity bit: 0 active high, 1 active low.
// - Grouping bit selects independent or common zero flags.
// - Control word is 16 bits: zero, 7-bit index, 8 data, MSB first.
// - Data commits to the indexed register on the latch rising edge.
module sdmc_top
    import sdmc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic control_bit_clock,
    input wire logic control_latch,
    input wire logic control_serial_in,
    input wire logic sample_tick,
    input wire logic left_zero_detect,
    input wire logic right_zero_detect,
    output sdmc_code_t left_level,
    output sdmc_code_t right_level,
    output logic left_output_disable,
    output logic right_output_disable,
    output logic oversample_select,
    output logic deemph_enable,
    output logic [1:0] deemph_rate_select,
    output logic [2:0] audio_format_select,
    output logic rolloff_select,
    output logic output_phase_invert,
    output logic left_zero_flag,
    output logic right_zero_flag
);
    // Link domain: shifter runs on the host bit clock
    logic [15:0] shift_q;
    logic [4:0] count_q;
    logic [14:0] word_q;
    logic frame_ok_q;
    logic latch_sync1_q;
    logic latch_sync2_q;
    logic latch_prev_q;
    logic shift_reset;

    assign shift_reset = control_latch;
    // Bit clock stops between frames, so a high latch clears the count asynchronously
    always_ff @(posedge control_bit_clock or posedge shift_reset) begin
        if (shift_reset) begin
            count_q <= 5'h00;
        end else if (count_q != `SDMC_WORD_BITS) begin
            count_q <= count_q + 5'h01;
        end
    end
    always_ff @(posedge control_bit_clock) begin
        if (!control_latch) begin
            shift_q <= {shift_q[14:0], control_serial_in};
        end
    end

    // Capture on latch rise: the bit clock has stopped, so the shifter is quiet
    always_ff @(posedge control_latch) begin
        word_q <= shift_q[14:0];
        frame_ok_q <= count_q == `SDMC_WORD_BITS && !shift_q[15];
    end

    // Latch crosses into sys_clk; it idles high, so reset high avoids a false rise
    logic [14:0] word_s_q;
    logic frame_ok_s_q;
    logic latch_rise;
    logic word_valid;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            latch_sync1_q <= 1'b1;
            latch_sync2_q <= 1'b1;
            latch_prev_q <= 1'b1;
        end else begin
            latch_sync1_q <= control_latch;
            latch_sync2_q <= latch_sync1_q;
            latch_prev_q <= latch_sync2_q;
        end
    end
    assign latch_rise = latch_sync2_q && !latch_prev_q;
    // Word settled at the latch edge, two cycles before its rise is seen here
    always_ff @(posedge sys_clk) begin
        word_s_q <= word_q;
        frame_ok_s_q <= frame_ok_q;
    end
    assign word_valid = latch_rise && frame_ok_s_q;

    wire [6:0] wr_idx = word_s_q[14:8];
    wire [7:0] wr_dat = word_s_q[7:0];
    wire wr_att_l = word_valid && wr_idx == `SDMC_IDX_ATT_L;
    wire wr_att_r = word_valid && wr_idx == `SDMC_IDX_ATT_R;
    wire wr_mute = word_valid && wr_idx == `SDMC_IDX_MUTE;
    wire wr_deemph = word_valid && wr_idx == `SDMC_IDX_DEEMPH;
    wire wr_format = word_valid && wr_idx == `SDMC_IDX_FORMAT;
    wire wr_phase = word_valid && wr_idx == `SDMC_IDX_PHASE;
    wire soft_reset_bit = wr_mute && wr_dat[`SDMC_B_SOFT_RESET_BIT];
    wire regs_clr = !rst_n || soft_reset_bit;
    wire dmf_ok = wr_dat[`SDMC_B_DMF_HI:`SDMC_B_DMF_LO] != `SDMC_DMF_RESERVED;
    wire fmt_ok = wr_dat[`SDMC_B_FMT_HI:`SDMC_B_FMT_LO] < `SDMC_FMT_RSV_MIN;

    sdmc_code_t att_l_q;
    sdmc_code_t att_r_q;
    logic [1:0] mute_q;
    logic over_q;
    logic [1:0] dis_q;
    logic deen_q;
    logic [1:0] dmf_q;
    logic [2:0] fmt_q;
    logic flt_q;
    logic output_phase_invert_q;
    logic zero_flag_polarity_q;
    logic zero_flag_grouping_q;

    always_ff @(posedge sys_clk) begin
        if (regs_clr) begin
            att_l_q <= `SDMC_ATT_RESET;
            att_r_q <= `SDMC_ATT_RESET;
            mute_q <= 2'h0;
            over_q <= 1'b0;
            dis_q <= 2'h0;
            deen_q <= 1'b0;
            dmf_q <= 2'h0;
            fmt_q <= `SDMC_FMT_RESET;
            flt_q <= 1'b0;
            output_phase_invert_q <= 1'b0;
            zero_flag_polarity_q <= 1'b0;
            zero_flag_grouping_q <= 1'b0;
        end else begin
            if (wr_att_l) begin
                att_l_q <= wr_dat;
            end
            if (wr_att_r) begin
                att_r_q <= wr_dat;
            end
            if (wr_mute) begin
                mute_q <= {wr_dat[`SDMC_B_MUTE_R], wr_dat[`SDMC_B_MUTE_L]};
                over_q <= wr_dat[`SDMC_B_OVER];
            end
            if (wr_deemph) begin
                dis_q <= {wr_dat[`SDMC_B_DIS_R], wr_dat[`SDMC_B_DIS_L]};
                deen_q <= wr_dat[`SDMC_B_DEEN];
                if (dmf_ok) begin
                    dmf_q <= wr_dat[`SDMC_B_DMF_HI:`SDMC_B_DMF_LO];
                end
            end
            if (wr_format) begin
                flt_q <= wr_dat[`SDMC_B_FLT];
                if (fmt_ok) begin
                    fmt_q <= wr_dat[`SDMC_B_FMT_HI:`SDMC_B_FMT_LO];
                end
            end
            if (wr_phase) begin
                output_phase_invert_q <= wr_dat[`SDMC_B_OUTPUT_PHASE_INVERT];
                zero_flag_polarity_q <= wr_dat[`SDMC_B_ZERO_FLAG_POLARITY];
                zero_flag_grouping_q <= wr_dat[`SDMC_B_ZERO_FLAG_GROUPING];
            end
        end
    end

    // Step timer: one step per 8 sample ticks, shared by both channels
    logic [3:0] fs_cnt_q;
    logic step;
    assign step = sample_tick && fs_cnt_q == `SDMC_STEP_FS - 4'h1;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fs_cnt_q <= 4'h0;
        end else if (step) begin
            fs_cnt_q <= 4'h0;
        end else if (sample_tick) begin
            fs_cnt_q <= fs_cnt_q + 4'h1;
        end
    end

    sdmc_code_t lvl [2];
    sdmc_code_t tgt [2];
    assign tgt[0] = att_l_q;
    assign tgt[1] = att_r_q;
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_ch
            sdmc_ramp u_ramp (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .clr(soft_reset_bit),
                .step(step),
                .target(tgt[ch]),
                .mute(mute_q[ch]),
                .level(lvl[ch])
            );
        end
    endgenerate
    // Applied code: 255 is 0 dB, 129 is -63 dB, 128 and below mute
    assign left_level = lvl[0];
    assign right_level = lvl[1];

    logic zl_q;
    logic zr_q;
    logic zl_s_q;
    logic zr_s_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            zl_s_q <= 1'b0;
            zr_s_q <= 1'b0;
            zl_q <= 1'b0;
            zr_q <= 1'b0;
        end else begin
            zl_s_q <= left_zero_detect;
            zr_s_q <= right_zero_detect;
            zl_q <= zl_s_q;
            zr_q <= zr_s_q;
        end
    end
    wire zero_common = zl_q && zr_q;
    wire zl_raw = zero_flag_grouping_q ? zero_common : zr_q;
    wire zr_raw = zero_flag_grouping_q ? 1'b0 : zl_q;

    logic zf_l_q;
    logic zf_r_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            zf_l_q <= 1'b0;
            zf_r_q <= 1'b0;
        end else begin
            zf_l_q <= zl_raw ^ zero_flag_polarity_q;
            zf_r_q <= zr_raw ^ zero_flag_polarity_q;
        end
    end
    // Pin 11 role carries right or common flag, pin 12 role carries left
    assign right_zero_flag = zf_l_q;
    assign left_zero_flag = zf_r_q;

    assign left_output_disable = dis_q[0];
    assign right_output_disable = dis_q[1];
    assign oversample_select = over_q;
    assign deemph_enable = deen_q;
    assign deemph_rate_select = dmf_q;
    assign audio_format_select = fmt_q;
    assign rolloff_select = flt_q;
    assign output_phase_invert = output_phase_invert_q;

    property p_unmapped;
        @(posedge sys_clk) disable iff (!rst_n)
        (word_valid && !(wr_att_l || wr_att_r || wr_mute || wr_deemph || wr_format || wr_phase))
        |=> $stable(att_l_q) && $stable(fmt_q) && $stable(mute_q);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped write changed state");

    property p_soft_reset_bit;
        @(posedge sys_clk) disable iff (!rst_n)
        soft_reset_bit |=> att_l_q == `SDMC_ATT_RESET && fmt_q == `SDMC_FMT_RESET && !mute_q[0];
    endproperty
    a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("Soft reset did not restore defaults");

    property p_fmt_rsv;
        @(posedge sys_clk) disable iff (!rst_n)
        fmt_q < `SDMC_FMT_RSV_MIN && dmf_q != `SDMC_DMF_RESERVED;
    endproperty
    a_fmt_rsv: assert property (p_fmt_rsv) else $error("Reserved code reached output");

    property p_att_write;
        @(posedge sys_clk) disable iff (!rst_n)
        wr_att_r && !soft_reset_bit |=> att_r_q == $past(wr_dat) && $stable(att_l_q);
    endproperty
    a_att_write: assert property (p_att_write) else $error("Right code write wrong");

    property p_mute_floor;
        @(posedge sys_clk) disable iff (!rst_n)
        (mute_q[0] && left_level == `SDMC_ATT_MUTE_MAX && !soft_reset_bit) |=> left_level == `SDMC_ATT_MUTE_MAX;
    endproperty
    a_mute_floor: assert property (p_mute_floor) else $error("Muted level left mute floor");

    property p_step_rate;
        @(posedge sys_clk) disable iff (!rst_n)
        step |-> fs_cnt_q == 4'h7;
    endproperty
    a_step_rate: assert property (p_step_rate) else $error("Step not on eighth sample");

    property p_zero_group;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(zero_flag_grouping_q) && $stable(zero_flag_grouping_q) && $stable(zero_flag_polarity_q) |-> left_zero_flag == zero_flag_polarity_q;
    endproperty
    a_zero_group: assert property (p_zero_group) else $error("Unused zero flag not idle");

    property p_zero_pol;
        @(posedge sys_clk) disable iff (!rst_n)
        !zero_flag_grouping_q && zr_q ##1 !zero_flag_grouping_q |-> right_zero_flag == !$past(zero_flag_polarity_q);
    endproperty
    a_zero_pol: assert property (p_zero_pol) else $error("Zero flag polarity wrong");

    property p_mute_down;
        @(posedge sys_clk) disable iff (!rst_n)
        mute_q[0] && left_level > `SDMC_ATT_MUTE_MAX && step && !soft_reset_bit
        |=> left_level == $past(left_level) - 8'h01;
    endproperty
    a_mute_down: assert property (p_mute_down) else $error("Muted level did not step down");

    property p_unmute_up;
        @(posedge sys_clk) disable iff (!rst_n)
        !mute_q[0] && left_level < att_l_q && att_l_q > `SDMC_ATT_MUTE_MAX && step && !soft_reset_bit
        |=> left_level == $past(left_level) + 8'h01;
    endproperty
    a_unmute_up: assert property (p_unmute_up) else $error("Level did not step up to the code");

    property p_level_floor;
        @(posedge sys_clk) disable iff (!rst_n)
        left_level >= `SDMC_ATT_MUTE_MAX && right_level >= `SDMC_ATT_MUTE_MAX;
    endproperty
    a_level_floor: assert property (p_level_floor) else $error("Level below the mute code");

    property p_short_frame;
        @(posedge sys_clk) disable iff (!rst_n)
        latch_rise && !frame_ok_s_q |=> $stable(over_q) && $stable(att_l_q) && $stable(fmt_q);
    endproperty
    a_short_frame: assert property (p_short_frame) else $error("Refused frame changed state");

    property p_disable;
        @(posedge sys_clk) disable iff (!rst_n)
        wr_deemph |=> left_output_disable == $past(wr_dat[`SDMC_B_DIS_L])
            && right_output_disable == $past(wr_dat[`SDMC_B_DIS_R]);
    endproperty
    a_disable: assert property (p_disable) else $error("Output disable bit not applied");

    property p_over;
        @(posedge sys_clk) disable iff (!rst_n)
        wr_mute && !soft_reset_bit |=> oversample_select == $past(wr_dat[`SDMC_B_OVER]);
    endproperty
    a_over: assert property (p_over) else $error("Oversampling bit not applied");
endmodule

// ==== verification/sdmc_host.sv ====
`timescale 1ns/1ps
module sdmc_host (
    output logic control_bit_clock,
    output logic control_latch,
    output logic control_serial_in
);
    // Bit clock idles low and only runs inside a frame
    initial begin
        control_bit_clock = 1'b0;
        control_latch = 1'b1;
        control_serial_in = 1'b0;
    end

    // Sends the top nbits of word; fewer than 16 makes a short frame
    task automatic send(input logic [15:0] word, input int nbits);
        int i;
        #3;
        control_latch = 1'b0;
        for (i = 15; i > 15 - nbits; i--) begin
            control_serial_in = word[i];
            #6 control_bit_clock = 1'b1;
            #6 control_bit_clock = 1'b0;
        end
        #6 control_latch = 1'b1;
        // Released line flips so a stale bit is never trusted
        control_serial_in = ~control_serial_in;
        #6;
    endtask
endmodule

// ==== verification/stereo_dac_mode_control_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module stereo_dac_mode_control_test;
    import sdmc_pkg::*;
    logic sys_clk;
    logic rst_n;
    logic sample_tick;
    logic left_zero_detect;
    logic right_zero_detect;
    wire logic control_bit_clock;
    wire logic control_latch;
    wire logic control_serial_in;
    sdmc_code_t left_level;
    sdmc_code_t right_level;
    logic left_output_disable;
    logic right_output_disable;
    logic oversample_select;
    logic deemph_enable;
    logic [1:0] deemph_rate_select;
    logic [2:0] audio_format_select;
    logic rolloff_select;
    logic output_phase_invert;
    logic left_zero_flag;
    logic right_zero_flag;
    wire logic [10:0] mode;
    int miscompares = 0;
    int comparisons = 0;
    int n;
    logic [15:0] wr [14] = '{16'h1240, 16'h1333, 16'h1350, 16'h1360, 16'h1420, 16'h1401, 16'h1402,
        16'h1403, 16'h1404, 16'h1406, 16'h1427, 16'h1601, 16'h157f, 16'h9313};
    logic [10:0] ex [14] = '{11'h450, 11'h6d3, 11'h750, 11'h550, 11'h508, 11'h510, 11'h520,
        11'h530, 11'h540, 11'h540, 11'h548, 11'h54c, 11'h54c, 11'h54c};

    assign mode = {oversample_select, deemph_enable, deemph_rate_select, audio_format_select,
        rolloff_select, output_phase_invert, left_output_disable, right_output_disable};

    sdmc_host HOST (
        .control_bit_clock(control_bit_clock),
        .control_latch(control_latch),
        .control_serial_in(control_serial_in)
    );

    sdmc_top DUT (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .control_bit_clock(control_bit_clock),
        .control_latch(control_latch),
        .control_serial_in(control_serial_in),
        .sample_tick(sample_tick),
        .left_zero_detect(left_zero_detect),
        .right_zero_detect(right_zero_detect),
        .left_level(left_level),
        .right_level(right_level),
        .left_output_disable(left_output_disable),
        .right_output_disable(right_output_disable),
        .oversample_select(oversample_select),
        .deemph_enable(deemph_enable),
        .deemph_rate_select(deemph_rate_select),
        .audio_format_select(audio_format_select),
        .rolloff_select(rolloff_select),
        .output_phase_invert(output_phase_invert),
        .left_zero_flag(left_zero_flag),
        .right_zero_flag(right_zero_flag)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // One sample period every two cycles keeps long ramps short
    always @(negedge sys_clk) begin
        sample_tick <= rst_n & ~sample_tick;
    end

    task automatic finish_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic put(input logic [15:0] w);
        HOST.send(w, 16);
        repeat (10) @(negedge sys_clk);
    endtask

    task automatic wait_lvl(input logic sel, input sdmc_code_t v, input int lim);
        int k;
        k = 0;
        while (((sel ? right_level : left_level) !== v) && k < lim) begin
            @(negedge sys_clk);
            k++;
        end
        `CHK(sel ? right_level : left_level, v)
        if (k >= lim) begin
            finish_test();
        end
    endtask

    initial begin
        rst_n = 1'b0;
        sample_tick = 1'b0;
        left_zero_detect = 1'b0;
        right_zero_detect = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        `CHK(mode, 11'h050)
        `CHK({left_level, right_level}, 16'hffff)
        `CHK({left_zero_flag, right_zero_flag}, 2'b00)
        for (int i = 0; i < 14; i++) begin
            put(wr[i]);
            `CHK(mode, ex[i])
        end
        left_zero_detect = 1'b1;
        put(16'h1600);
        `CHK({left_zero_flag, right_zero_flag}, 2'b10)
        put(16'h1602);
        `CHK({left_zero_flag, right_zero_flag}, 2'b01)
        put(16'h1606);
        `CHK({left_zero_flag, right_zero_flag}, 2'b11)
        right_zero_detect = 1'b1;
        repeat (8) @(negedge sys_clk);
        `CHK({left_zero_flag, right_zero_flag}, 2'b10)
        put(16'h10fb);
        // First steps may land inside put; time a whole later interval
        wait_lvl(1'b0, 8'hfc, 200);
        n = 0;
        for (int j = 0; j < 40 && left_level !== 8'hfb; j++) begin
            @(negedge sys_clk);
            #1;
            if (sample_tick === 1'b1) n++;
        end
        `CHK(n, 8)
        `CHK(right_level, 8'hff)
        put(16'h1201);
        wait_lvl(1'b0, 8'h80, 2500);
        `CHK(right_level, 8'hff)
        repeat (40) @(negedge sys_clk);
        `CHK(left_level, 8'h80)
        put(16'h1200);
        wait_lvl(1'b0, 8'hfb, 3000);
        put(16'h1105);
        wait_lvl(1'b1, 8'h80, 2500);
        put(16'h1181);
        wait_lvl(1'b1, 8'h81, 40);
        repeat (40) @(negedge sys_clk);
        `CHK(right_level, 8'h81)
        put(16'h1280);
        `CHK(mode, 11'h050)
        `CHK({left_level, right_level}, 16'hffff)
        HOST.send(16'h1240, 12);
        repeat (10) @(negedge sys_clk);
        `CHK(oversample_select, 1'b0)
        put(16'h1240);
        `CHK(oversample_select, 1'b1)
        rst_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        `CHK(mode, 11'h050)
        `CHK({left_level, right_level}, 16'hffff)
        finish_test();
    end
endmodule
